// *** logic/alarm_matrix.sv ***
// Purpose: receive, transmit and common alarm matrix with masks and latches
// Assumes: detector inputs are pin levels, active high when the fault is present
// Notes:   all outputs come from flip-flops; registers over a plain strobe port
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
`include "alarm_matrix_defines.svh"

module alarm_matrix
	import alarm_matrix_pkg::*;
(
	input  wire logic               clk_i,
	input  wire logic               reset_i,
	// receive fault detectors
	input  wire logic               carrier_absent_i,
	input  wire logic               rx_if_synth_lock_loss_i,
	input  wire logic               rx_oversample_lock_loss_i,
	input  wire logic               rx_alarm_indication_received_i,
	input  wire logic               rx_gain_level_low_i,
	input  wire logic               demultiplexer_lock_loss_i,
	// transmit and common fault detectors
	input  wire logic               tx_hw_fault_i,
	input  wire logic               tx_ext_fault_i,
	input  wire logic               common_hw_fault_i,
	input  wire logic               common_ext_fault_i,
	// register port
	input  wire logic [`ADDR_W-1:0] addr_i,
	input  wire logic [`DATA_W-1:0] wr_data_i,
	input  wire logic               wr_i,
	input  wire logic               rd_i,
	output logic      [`DATA_W-1:0] rd_data_o,
	// receive actions
	output logic                    rx_major_led_o,
	output logic                    rx_minor_led_o,
	output logic                    rx_ais_insert_o,
	output logic                    demod_fault_contact_o,
	output logic                    demod_fault_oc_output_o,
	output logic                    far_end_alarm_out_o,
	// transmit actions
	output logic                    tx_major_led_o,
	output logic                    tx_minor_led_o,
	output logic                    tx_if_off_o,
	output logic                    mod_fault_contact_o,
	output logic                    mod_fault_oc_output_o,
	// common actions
	output logic                    common_fault_contact_o,
	output logic                    switch_common_fault_contact_o,
	output logic                    minor_alarm_contact_o
);

	// output vector positions
	localparam int O_RX_MAJOR  = 0;
	localparam int O_RX_MINOR  = 1;
	localparam int O_RX_AIS    = 2;
	localparam int O_DEMOD_REL = 3;
	localparam int O_DEMOD_OC  = 4;
	localparam int O_FAR_END   = 5;
	localparam int O_TX_MAJOR  = 6;
	localparam int O_TX_MINOR  = 7;
	localparam int O_TX_IF_OFF = 8;
	localparam int O_MOD_REL   = 9;
	localparam int O_MOD_OC    = 10;
	localparam int O_COM_REL   = 11;
	localparam int O_SW_COM    = 12;
	localparam int O_MINOR_REL = 13;

	matrix_state_t       state_q;
	matrix_state_t       state_d;
	logic [`FAULT_W-1:0] fault_raw;
	logic [`FAULT_W-1:0] fault_s;
	logic [`FAULT_W-1:0] fault_q;
	logic                rx_major_raw;
	logic                rx_minor_raw;
	logic                rx_any_raw;
	logic                rx_major_act;
	logic                rx_minor_act;
	logic                demod_rel_act;
	logic                demod_oc_act;
	logic                tx_major_act;
	logic                tx_minor_act;
	logic                com_major_act;
	logic                com_minor_act;
	logic [`OUT_W-1:0]   outs_next;
	logic                wr_mask;
	logic                wr_clear;

	// gather the detector pins into one vector
	always_comb begin
		fault_raw                    = '0;
		fault_raw[`F_CARRIER_ABSENT] = carrier_absent_i;
		fault_raw[`F_IF_SYNTH_LOSS]  = rx_if_synth_lock_loss_i;
		fault_raw[`F_OVERSAMP_LOSS]  = rx_oversample_lock_loss_i;
		fault_raw[`F_AIS_RECEIVED]   = rx_alarm_indication_received_i;
		fault_raw[`F_GAIN_LOW]       = rx_gain_level_low_i;
		fault_raw[`F_DEMUX_LOSS]     = demultiplexer_lock_loss_i;
		fault_raw[`F_TX_HW]          = tx_hw_fault_i;
		fault_raw[`F_TX_EXT]         = tx_ext_fault_i;
		fault_raw[`F_COM_HW]         = common_hw_fault_i;
		fault_raw[`F_COM_EXT]        = common_ext_fault_i;
	end

	// detector levels cross into the clock domain
	fault_sync u_sync (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.async_i (fault_raw),
		.sync_o  (fault_s)
	);

	// masked view of each fault
	assign fault_q = fault_s & ~state_q.mask;

	// receive group, unmasked raw classes feed AIS and far end
	always_comb begin
		rx_major_raw = fault_s[`F_IF_SYNTH_LOSS]
			| fault_s[`F_OVERSAMP_LOSS];
		rx_minor_raw = fault_s[`F_CARRIER_ABSENT]
			| fault_s[`F_AIS_RECEIVED]
			| fault_s[`F_GAIN_LOW]
			| fault_s[`F_DEMUX_LOSS];
		rx_any_raw   = rx_major_raw | rx_minor_raw;
	end

	// receive group, masked terms for LEDs, relay and OC output
	always_comb begin
		rx_major_act  = fault_q[`F_IF_SYNTH_LOSS]
			| fault_q[`F_OVERSAMP_LOSS];
		rx_minor_act  = fault_q[`F_CARRIER_ABSENT]
			| fault_q[`F_AIS_RECEIVED]
			| fault_q[`F_GAIN_LOW]
			| fault_q[`F_DEMUX_LOSS];
		demod_rel_act = fault_q[`F_DEMUX_LOSS]
			| fault_q[`F_IF_SYNTH_LOSS]
			| fault_q[`F_OVERSAMP_LOSS];
		demod_oc_act  = fault_q[`F_CARRIER_ABSENT]
			| fault_q[`F_IF_SYNTH_LOSS]
			| fault_q[`F_OVERSAMP_LOSS]
			| fault_q[`F_GAIN_LOW]
			| fault_q[`F_DEMUX_LOSS];
	end

	// transmit group, fed only by transmit faults
	always_comb begin
		tx_major_act = fault_q[`F_TX_HW];
		tx_minor_act = fault_q[`F_TX_EXT];
	end

	// common group, belongs to neither path alone
	always_comb begin
		com_major_act = fault_q[`F_COM_HW];
		com_minor_act = fault_q[`F_COM_EXT];
	end

	// map the classes onto the action vector
	always_comb begin
		outs_next              = '0;
		outs_next[O_RX_MAJOR]  = rx_major_act;
		outs_next[O_RX_MINOR]  = rx_minor_act;
		outs_next[O_RX_AIS]    = rx_any_raw;
		outs_next[O_DEMOD_REL] = demod_rel_act;
		outs_next[O_DEMOD_OC]  = demod_oc_act;
		outs_next[O_FAR_END]   = rx_any_raw;
		outs_next[O_TX_MAJOR]  = tx_major_act;
		outs_next[O_TX_MINOR]  = tx_minor_act;
		outs_next[O_TX_IF_OFF] = tx_major_act;
		outs_next[O_MOD_REL]   = tx_major_act;
		outs_next[O_MOD_OC]    = tx_major_act | tx_minor_act;
		outs_next[O_COM_REL]   = com_major_act;
		outs_next[O_SW_COM]    = com_major_act;
		outs_next[O_MINOR_REL] = com_minor_act | tx_minor_act | rx_minor_act;
	end

	// register write decode
	always_comb begin
		wr_mask  = wr_i && (addr_i == `ADDR_MASK);
		wr_clear = wr_i && (addr_i == `ADDR_CLEAR);
	end

	// next state of the whole block
	always_comb begin
		state_d      = state_q;
		state_d.outs = outs_next;
		// mask register takes the low bits of a write
		if (wr_mask) begin
			state_d.mask = wr_data_i[`FAULT_W-1:0];
		end
		// latch clear empties all bits, present faults set again
		if (wr_clear) begin
			state_d.latched = fault_s;
		end else begin
			state_d.latched = state_q.latched | fault_s;
		end
		// read data stand one cycle after the read strobe
		state_d.rd_data = '0;
		if (rd_i) begin
			unique case (addr_i)
				`ADDR_LIVE: begin
					state_d.rd_data = {{(`DATA_W-`FAULT_W){1'b0}}, fault_s};
				end
				`ADDR_LATCHED: begin
					state_d.rd_data = {{(`DATA_W-`FAULT_W){1'b0}}, state_q.latched};
				end
				`ADDR_MASK: begin
					state_d.rd_data = {{(`DATA_W-`FAULT_W){1'b0}}, state_q.mask};
				end
				`ADDR_OUTPUTS: begin
					state_d.rd_data = {{(`DATA_W-`OUT_W){1'b0}}, state_q.outs};
				end
				default: begin
					state_d.rd_data = '0;
				end
			endcase
		end
	end

	// register the block state
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state_q.mask    <= `MASK_RESET;
			state_q.latched <= `LATCH_RESET;
			state_q.rd_data <= '0;
			state_q.outs    <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	// ports driven straight from the state flops
	assign rd_data_o                     = state_q.rd_data;
	assign rx_major_led_o                = state_q.outs[O_RX_MAJOR];
	assign rx_minor_led_o                = state_q.outs[O_RX_MINOR];
	assign rx_ais_insert_o               = state_q.outs[O_RX_AIS];
	assign demod_fault_contact_o         = state_q.outs[O_DEMOD_REL];
	assign demod_fault_oc_output_o       = state_q.outs[O_DEMOD_OC];
	assign far_end_alarm_out_o           = state_q.outs[O_FAR_END];
	assign tx_major_led_o                = state_q.outs[O_TX_MAJOR];
	assign tx_minor_led_o                = state_q.outs[O_TX_MINOR];
	assign tx_if_off_o                   = state_q.outs[O_TX_IF_OFF];
	assign mod_fault_contact_o           = state_q.outs[O_MOD_REL];
	assign mod_fault_oc_output_o         = state_q.outs[O_MOD_OC];
	assign common_fault_contact_o        = state_q.outs[O_COM_REL];
	assign switch_common_fault_contact_o = state_q.outs[O_SW_COM];
	assign minor_alarm_contact_o         = state_q.outs[O_MINOR_REL];

endmodule

// *** logic/alarm_matrix_defines.svh ***
// Purpose: constants for the modem alarm and fault matrix block
// Assumes: 25 MHz system clock, word-wide register port
// Notes:   fault positions index the live, latched and mask vectors
`ifndef ALARM_MATRIX_DEFINES_SVH
`define ALARM_MATRIX_DEFINES_SVH

// vector widths
`define FAULT_W          10
`define OUT_W            14
`define ADDR_W           8
`define DATA_W           32

// fault positions, receive group
`define F_CARRIER_ABSENT 0
`define F_IF_SYNTH_LOSS  1
`define F_OVERSAMP_LOSS  2
`define F_AIS_RECEIVED   3
`define F_GAIN_LOW       4
`define F_DEMUX_LOSS     5
// fault positions, transmit and common groups
`define F_TX_HW          6
`define F_TX_EXT         7
`define F_COM_HW         8
`define F_COM_EXT        9

// register byte addresses
`define ADDR_LIVE        8'h00
`define ADDR_LATCHED     8'h04
`define ADDR_MASK        8'h08
`define ADDR_CLEAR       8'h0c
`define ADDR_OUTPUTS     8'h10

// reset values
`define MASK_RESET       10'h000
`define LATCH_RESET      10'h000

`endif

// *** logic/alarm_matrix_pkg.sv ***
// Purpose: types shared by the alarm matrix files
// Assumes: alarm_matrix_defines.svh gives the widths
// Notes:   one packed struct carries all state of the top module
`include "alarm_matrix_defines.svh"

package alarm_matrix_pkg;

	// complete register state of the matrix
	typedef struct packed {
		logic [`FAULT_W-1:0] mask;
		logic [`FAULT_W-1:0] latched;
		logic [`DATA_W-1:0]  rd_data;
		logic [`OUT_W-1:0]   outs;
	} matrix_state_t;

	// state of the input synchroniser
	typedef struct packed {
		logic [`FAULT_W-1:0] stage1;
		logic [`FAULT_W-1:0] stage2;
	} sync_state_t;

endpackage

// *** logic/fault_sync.sv ***
// Purpose: two-stage synchroniser for the fault detector pins
// Assumes: detector levels are asynchronous to clk_i
// Notes:   stage1 feeds only stage2
`timescale 1ns/100ps
`include "alarm_matrix_defines.svh"

module fault_sync
	import alarm_matrix_pkg::*;
(
	input  wire logic                clk_i,
	input  wire logic                reset_i,
	input  wire logic [`FAULT_W-1:0] async_i,
	output logic      [`FAULT_W-1:0] sync_o
);

	sync_state_t state_q;
	sync_state_t state_d;

	// shift the pin levels through two stages
	always_comb begin
		state_d        = state_q;
		state_d.stage1 = async_i;
		state_d.stage2 = state_q.stage1;
	end

	// register the synchroniser state
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign sync_o = state_q.stage2;

endmodule

// *** sim/alarm_matrix_checker.sv ***
// Purpose: port assertions for the alarm matrix
// Assumes: two-flop input sync, outputs one flop later
// Notes:   mask mirrored from register writes
`timescale 1ns/100ps
`include "alarm_matrix_defines.svh"

module alarm_matrix_checker (
	input wire logic        clk_i,
	input wire logic        reset_i,
	input wire logic        carrier_absent_i,
	input wire logic        rx_if_synth_lock_loss_i,
	input wire logic        rx_oversample_lock_loss_i,
	input wire logic        rx_alarm_indication_received_i,
	input wire logic        rx_gain_level_low_i,
	input wire logic        demultiplexer_lock_loss_i,
	input wire logic        tx_hw_fault_i,
	input wire logic        tx_ext_fault_i,
	input wire logic        common_hw_fault_i,
	input wire logic        common_ext_fault_i,
	input wire logic [7:0]  addr_i,
	input wire logic [31:0] wr_data_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [31:0] rd_data_o,
	input wire logic        rx_major_led_o,
	input wire logic        rx_minor_led_o,
	input wire logic        rx_ais_insert_o,
	input wire logic        demod_fault_contact_o,
	input wire logic        demod_fault_oc_output_o,
	input wire logic        far_end_alarm_out_o,
	input wire logic        tx_major_led_o,
	input wire logic        tx_minor_led_o,
	input wire logic        tx_if_off_o,
	input wire logic        mod_fault_contact_o,
	input wire logic        mod_fault_oc_output_o,
	input wire logic        common_fault_contact_o,
	input wire logic        switch_common_fault_contact_o
);
	logic [9:0] p1_q;
	logic [9:0] p2_q;
	logic [9:0] m_q;
	logic [9:0] un;

	// mirror of the input sync and the mask register
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			{p1_q, p2_q, m_q} <= '0;
		end else begin
			p1_q <= {common_ext_fault_i, common_hw_fault_i, tx_ext_fault_i, tx_hw_fault_i,
				demultiplexer_lock_loss_i, rx_gain_level_low_i,
				rx_alarm_indication_received_i, rx_oversample_lock_loss_i,
				rx_if_synth_lock_loss_i, carrier_absent_i};
			p2_q <= p1_q;
			if (wr_i && addr_i == `ADDR_MASK)
				m_q <= wr_data_i[9:0];
		end
	end
	assign un = p2_q & ~m_q;

	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);

	sequence mask_wr;
		wr_i && addr_i == `ADDR_MASK;
	endsequence
	sequence mask_rd;
		rd_i && addr_i == `ADDR_MASK;
	endsequence

	a_rx_major_led: assert property (rx_major_led_o == $past(un[1] | un[2]))
		else $error("rx major led wrong");
	a_rx_minor_led: assert property (rx_minor_led_o == $past(|{un[0], un[3], un[4], un[5]}))
		else $error("rx minor led wrong");
	a_rx_ais_follow: assert property (rx_ais_insert_o == $past(|p2_q[5:0]))
		else $error("rx ais insertion wrong");
	a_far_end_alarm: assert property (far_end_alarm_out_o == $past(|p2_q[5:0]))
		else $error("far end alarm missing");
	a_demod_oc_out: assert property (demod_fault_oc_output_o ==
		$past(|{un[0], un[1], un[2], un[4], un[5]}))
		else $error("demod oc output wrong");
	a_demod_relay: assert property (demod_fault_contact_o == $past(|{un[1], un[2], un[5]}))
		else $error("demod relay wrong");
	a_rx_isolated: assert property ($past(p2_q[9:6]) == 4'h0 |-> {tx_major_led_o,
		tx_minor_led_o, tx_if_off_o, mod_fault_contact_o, mod_fault_oc_output_o,
		common_fault_contact_o, switch_common_fault_contact_o} == 7'h00)
		else $error("receive fault reached transmit side");
	a_tx_major_own: assert property (tx_major_led_o == $past(un[6]))
		else $error("tx major led wrong");
	a_mask_readback: assert property (mask_wr ##1 mask_rd |->
		##1 rd_data_o == {22'h0, $past(wr_data_i[9:0], 2)})
		else $error("mask readback wrong");
	a_rd_idle_zero: assert property (!$past(rd_i) |-> rd_data_o == 32'h0)
		else $error("read data outside read slot");
endmodule

bind alarm_matrix alarm_matrix_checker u_chk (.*);

// *** sim/alarm_matrix_tb.sv ***
// Purpose: self-checking bench for the alarm matrix
// Assumes: 25 MHz clock, fault pins from fault_source
// Notes:   random faults and masks plus latch corners
`timescale 1ns/100ps
`include "alarm_matrix_defines.svh"

module alarm_matrix_tb;
	logic        clk_i = 0;
	logic        reset_i = 1;
	logic [9:0]  cmd = '0;
	logic [9:0]  pins;
	logic [13:0] outs;
	logic [7:0]  addr = '0;
	logic [31:0] wdata = '0;
	logic        wr_s = 0;
	logic        rd_s = 0;
	logic [31:0] rd_w;
	logic [31:0] rdata;
	int          err_total = 0;
	int          tests_run = 0;
	int          cyc = 0;

	// 40 ns clock
	always #20 clk_i = ~clk_i;

	fault_source src (.clk_i(clk_i), .cmd_i(cmd), .fault_o(pins));

	alarm_matrix dut (.clk_i(clk_i), .reset_i(reset_i),
		.carrier_absent_i(pins[0]), .rx_if_synth_lock_loss_i(pins[1]),
		.rx_oversample_lock_loss_i(pins[2]), .rx_alarm_indication_received_i(pins[3]),
		.rx_gain_level_low_i(pins[4]), .demultiplexer_lock_loss_i(pins[5]),
		.tx_hw_fault_i(pins[6]), .tx_ext_fault_i(pins[7]),
		.common_hw_fault_i(pins[8]), .common_ext_fault_i(pins[9]),
		.addr_i(addr), .wr_data_i(wdata), .wr_i(wr_s), .rd_i(rd_s), .rd_data_o(rd_w),
		.rx_major_led_o(outs[0]), .rx_minor_led_o(outs[1]), .rx_ais_insert_o(outs[2]),
		.demod_fault_contact_o(outs[3]), .demod_fault_oc_output_o(outs[4]),
		.far_end_alarm_out_o(outs[5]), .tx_major_led_o(outs[6]),
		.tx_minor_led_o(outs[7]), .tx_if_off_o(outs[8]),
		.mod_fault_contact_o(outs[9]), .mod_fault_oc_output_o(outs[10]),
		.common_fault_contact_o(outs[11]), .switch_common_fault_contact_o(outs[12]),
		.minor_alarm_contact_o(outs[13]));

	// expected output vector for faults f under mask m
	function automatic logic [13:0] exp_out(logic [9:0] f, logic [9:0] m);
		logic [9:0] u;
		logic       mn;
		u = f & ~m;
		mn = u[0] | u[3] | u[4] | u[5];
		return {u[7] | u[9] | mn, u[8], u[8], u[6] | u[7], u[6], u[6], u[7], u[6],
			|f[5:0], u[0] | u[1] | u[2] | u[4] | u[5], u[1] | u[2] | u[5], |f[5:0], mn,
			u[1] | u[2]};
	endfunction

	task automatic chk(string name, logic [31:0] exp, logic [31:0] act);
		tests_run++;
		if (act !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", name, exp, act);
		end
	endtask

	task automatic summarize();
		if (err_total == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// one-cycle write strobe
	task automatic wr(logic [7:0] a, logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr_s <= 1;
		@(posedge clk_i);
		wr_s <= 0;
	endtask

	// one-cycle read strobe, data taken in the next cycle
	task automatic rd(logic [7:0] a);
		addr <= a;
		rd_s <= 1;
		@(posedge clk_i);
		rd_s <= 0;
		#1 rdata = rd_w;
		@(posedge clk_i);
	endtask

	// set mask and faults, then check pins and registers
	task automatic apply(logic [9:0] fv, logic [9:0] mv);
		wr(`ADDR_MASK, {22'h0, mv});
		rd(`ADDR_MASK);
		chk("mask", {22'h0, mv}, rdata);
		cmd <= fv;
		repeat (6) @(posedge clk_i);
		chk("pins", {18'h0, exp_out(fv, mv)}, {18'h0, outs});
		rd(`ADDR_OUTPUTS);
		chk("outvec", {18'h0, exp_out(fv, mv)}, rdata);
		rd(`ADDR_LIVE);
		chk("live", {22'h0, fv}, rdata);
	endtask

	// hang guard
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			summarize();
		end
	end

	initial begin
		void'($urandom(32'h4a99));
		repeat (4) @(posedge clk_i);
		#1 chk("reset outs", 32'h0, {18'h0, outs});
		@(posedge clk_i);
		reset_i <= 0;
		@(posedge clk_i);
		for (int i = 0; i < 10; i++)
			apply(10'h1 << i, 10'h0);
		apply(10'h0, 10'h0);
		rd(`ADDR_LATCHED);
		chk("latched all", 32'h3ff, rdata);
		apply(10'h3ff, 10'h3ff);
		apply(10'h03f, 10'h000);
		for (int i = 0; i < 24; i++)
			apply(10'($urandom), 10'($urandom));
		apply(10'h0, 10'h0);
		wr(`ADDR_CLEAR, 32'h0);
		@(posedge clk_i);
		apply(10'h008, 10'h0);
		apply(10'h0, 10'h0);
		wr(`ADDR_LATCHED, 32'h0);
		rd(`ADDR_LATCHED);
		chk("latch held", 32'h008, rdata);
		rd(8'h14);
		chk("unmapped", 32'h0, rdata);
		apply(10'h020, 10'h0);
		wr(`ADDR_CLEAR, 32'h0);
		rd(`ADDR_LATCHED);
		chk("clear set wins", 32'h020, rdata);
		apply(10'h0, 10'h0);
		wr(`ADDR_CLEAR, 32'h1);
		rd(`ADDR_LATCHED);
		chk("final clear", 32'h0, rdata);
		summarize();
	end
endmodule

// *** sim/fault_source.sv ***
// Purpose: fault detector model feeding the matrix pins
// Assumes: bench commands levels at the clock edge
// Notes:   detectors hold a level while the fault lasts
`timescale 1ns/100ps

module fault_source (
	input  wire logic       clk_i,
	input  wire logic [9:0] cmd_i,
	output logic      [9:0] fault_o
);
	// detector levels change one edge after the command
	always_ff @(posedge clk_i) begin
		fault_o <= cmd_i;
	end
endmodule
